// File: include/lcr_consts.svh
`ifndef LCR_CONSTS_SVH
`define LCR_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets on the local address lines
// ----------------------------------------------------------------
`define LCR_OFS_VERSION 8'h00
`define LCR_OFS_MISC 8'h04
`define LCR_OFS_CTRL 8'h08

// ----------------------------------------------------------------
// Address space bounds
// ----------------------------------------------------------------
`define LCR_CFG_LAST 8'h50
`define LCR_ISO_FIRST 8'h54
`define LCR_ISO_LAST 8'h5C
`define LCR_FIFO_FIRST 8'h80
`define LCR_FIFO_LAST 8'hCC

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LCR_ACK_LSB 23
`define LCR_ACK_MSB 27
`define LCR_SIDR_BIT 1
`define LCR_BUSY_LSB 2
`define LCR_BUSY_MSB 4
`define LCR_TRANSMITTER_EN_BIT 5
`define LCR_RECEIVER_EN_BIT 6
`define LCR_TXRST_BIT 10
`define LCR_RXRST_BIT 11

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define LCR_CTRL_RST 32'h0200_0000
`define LCR_ACK_RST 5'h00
`define LCR_CTRL_WMASK 32'h0FF3_8C7E
`define LCR_POR_SET 32'h0000_0042
`define LCR_RDATA_RST 32'h0000_0000

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define LCR_SYNC_STAGES 2

`endif

// File: include/lcr_pkg.sv
package lcr_pkg;

	// ------------------------------------------------------------
	// Local bus pins as one carrier
	// ------------------------------------------------------------
	typedef struct packed {
		logic cs_b;
		logic we_b;
		logic [7:0] addr;
		logic [31:0] wdata;
	} lcr_lbus_t;

	// ------------------------------------------------------------
	// Address regions, one-hot
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		LCR_REG_CFG = 4'h1,
		LCR_REG_ISO = 4'h2,
		LCR_REG_FIFO = 4'h4,
		LCR_REG_RSVD = 4'h8
	} lcr_region_t;

	// ------------------------------------------------------------
	// Retry codes carried by incoming packets
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		LCR_RETRY_NEW = 2'h0,
		LCR_RETRY_X = 2'h1,
		LCR_RETRY_A = 2'h2,
		LCR_RETRY_B = 2'h3
	} lcr_retry_t;

	// ------------------------------------------------------------
	// Busy acknowledge flavours
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		LCR_BUSY_X = 2'h0,
		LCR_BUSY_A = 2'h1,
		LCR_BUSY_B = 2'h2
	} lcr_busy_kind_t;

endpackage : lcr_pkg

// File: core/lcr_busy_sel.sv
`timescale 1ns/1ps

module lcr_busy_sel
	import lcr_pkg::*;
(
	// Policy from the control register
	input wire logic [2:0] policy_i,
	// Receiver request
	input wire logic busy_needed_i,
	input wire lcr_retry_t retry_i,
	// Decision
	output logic send_busy_o,
	output lcr_busy_kind_t kind_o
);

	// --------------------------------------------------------------
	// Normal busy/retry protocol: answer in the phase of the retry
	// --------------------------------------------------------------
	function automatic lcr_busy_kind_t follow_retry(input lcr_retry_t r);
		lcr_busy_kind_t k;
		k = LCR_BUSY_X;
		unique case (r)
			LCR_RETRY_A: k = LCR_BUSY_A;
			LCR_RETRY_B: k = LCR_BUSY_B;
			LCR_RETRY_X: k = LCR_BUSY_X;
			LCR_RETRY_NEW: k = LCR_BUSY_X;
		endcase
		return k;
	endfunction : follow_retry

	wire logic always_busy;
	wire logic [1:0] flavour;

	// Bit 2 of the field selects unconditional busy
	assign always_busy = policy_i[2];
	assign flavour = policy_i[1:0];
	assign send_busy_o = always_busy | busy_needed_i;

	// Reserved flavour 11 falls back to the normal protocol
	assign kind_o = (flavour == 2'h1) ? LCR_BUSY_A :
		(flavour == 2'h2) ? LCR_BUSY_B :
		follow_retry(retry_i);

endmodule : lcr_busy_sel

// File: core/lcr_front.sv
`timescale 1ns/1ps
`include "lcr_consts.svh"

// Contract
// - Identification word at offset zero is read only; writes do nothing.
// - Decode config, isochronous, FIFO and reserved regions of the space.
// - Capture last transmit acknowledge code into misc bits 23 to 27.
// - Host writes to acknowledge field only while diagnostic write is set.
// - Device reset loads control register with 0200_0000h.
// - Self-ID receive bit collects self-ID packets as one packet; default one.
// - Busy policies 000, 001, 010 send busy only when needed.
// - Busy policies 100, 101, 110 busy every packet; 011, 111 reserved.
// - Incoming retry_X needing busy is answered with ack_busy_X under busy policies 000, 011, 100, 111.
// - Transmitter enable clear stops arbitration; bus reset clears it.
// - Receiver enable clear stops reception; set at power-on, bus reset keeps.
// - Transmitter and receiver soft reset bits pulse a reset, self-clear.

module lcr_front
	import lcr_pkg::*;
#(
	// Arbitrary identification value
	parameter logic [31:0] VERSION_ID = 32'h5A5A_0001,
	parameter int SYNC_STAGES = `LCR_SYNC_STAGES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Local bus pins
	input wire logic lb_cs_b_i,
	input wire logic lb_we_b_i,
	input wire logic [7:0] local_address_lines_i,
	input wire logic [31:0] lb_wdata_i,
	output logic [31:0] lb_rdata_o,
	output logic lb_ack_o,
	output lcr_region_t lb_region_o,
	// Link status inputs
	input wire logic diag_register_write_i,
	input wire logic bus_reset_i,
	input wire logic ack_valid_i,
	input wire logic [4:0] ack_code_i,
	// Receiver busy request
	input wire logic rx_busy_req_i,
	input wire logic rx_busy_needed_i,
	input wire lcr_retry_t rx_retry_i,
	// Control outputs
	output logic self_id_receive_en_o,
	output logic [2:0] busy_ack_policy_o,
	output logic transmitter_en_o,
	output logic receiver_en_o,
	output logic transmitter_soft_reset_o,
	output logic receiver_soft_reset_o,
	// Busy acknowledge decision
	output logic ack_busy_valid_o,
	output logic ack_busy_send_o,
	output lcr_busy_kind_t ack_busy_kind_o
);

	// --------------------------------------------------------------
	// Elaboration checks
	// --------------------------------------------------------------
	if (SYNC_STAGES < 2) begin : g_bad_sync
		$error("lcr_front: SYNC_STAGES must be at least 2");
	end

	// --------------------------------------------------------------
	// Pin synchroniser
	// --------------------------------------------------------------
	// Address and data are sampled with the strobe; the host holds
	// them steady while chip select is low, so per-bit skew is safe.
	lcr_lbus_t pins;
	lcr_lbus_t sync_q [SYNC_STAGES];
	lcr_lbus_t bus;
	logic cs_b_prev_q;

	assign pins = '{cs_b: lb_cs_b_i, we_b: lb_we_b_i,
		addr: local_address_lines_i, wdata: lb_wdata_i};
	assign bus = sync_q[SYNC_STAGES-1];

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < SYNC_STAGES; i++) begin
				sync_q[i] <= '{cs_b: 1'b1, we_b: 1'b1, addr: 8'h00,
					wdata: 32'h0000_0000};
			end
		end else begin
			sync_q[0] <= pins;
			for (int i = 1; i < SYNC_STAGES; i++) begin
				sync_q[i] <= sync_q[i-1];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cs_b_prev_q <= 1'b1;
		end else begin
			cs_b_prev_q <= bus.cs_b;
		end
	end

	// --------------------------------------------------------------
	// Address decode
	// --------------------------------------------------------------
	function automatic lcr_region_t region_of(input logic [7:0] a);
		lcr_region_t r;
		r = LCR_REG_RSVD;
		if (a <= `LCR_CFG_LAST) begin
			r = LCR_REG_CFG;
		end else if (a >= `LCR_ISO_FIRST && a <= `LCR_ISO_LAST) begin
			r = LCR_REG_ISO;
		end else if (a >= `LCR_FIFO_FIRST && a <= `LCR_FIFO_LAST) begin
			r = LCR_REG_FIFO;
		end
		return r;
	endfunction : region_of

	wire logic take;
	wire logic wr_take;
	wire logic rd_take;
	wire logic wr_misc;
	wire logic wr_ctrl;
	wire lcr_region_t region;

	// One access per falling edge of chip select
	assign take = !bus.cs_b && cs_b_prev_q;
	assign wr_take = take && !bus.we_b;
	assign rd_take = take && bus.we_b;
	assign region = region_of(bus.addr);
	// No write path exists for the identification word
	assign wr_misc = wr_take && (bus.addr == `LCR_OFS_MISC);
	assign wr_ctrl = wr_take && (bus.addr == `LCR_OFS_CTRL);

	// --------------------------------------------------------------
	// Misc register: last acknowledge code
	// --------------------------------------------------------------
	logic [4:0] ack_q;
	logic [4:0] ack_d;

	// A code arriving from the transmitter beats a diagnostic write
	assign ack_d = ack_valid_i ? ack_code_i :
		(wr_misc && diag_register_write_i) ?
		bus.wdata[`LCR_ACK_MSB:`LCR_ACK_LSB] : ack_q;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_q <= `LCR_ACK_RST;
		end else begin
			ack_q <= ack_d;
		end
	end

	// --------------------------------------------------------------
	// Control register
	// --------------------------------------------------------------
	logic [31:0] ctrl_q;
	logic [31:0] ctrl_d;
	logic por_q;
	wire logic [31:0] ctrl_cleared;
	wire logic [31:0] ctrl_por;
	wire logic [31:0] ctrl_wr;

	// Soft reset bits last one cycle unless rewritten
	assign ctrl_cleared = ctrl_q & ~((32'h1 << `LCR_TXRST_BIT) |
		(32'h1 << `LCR_RXRST_BIT));
	// Power-on defaults land one cycle after release
	assign ctrl_por = por_q ? (ctrl_cleared | `LCR_POR_SET) :
		ctrl_cleared;
	// Host write replaces the word; reserved bits stay zero
	assign ctrl_wr = wr_ctrl ? (bus.wdata & `LCR_CTRL_WMASK) :
		ctrl_por;

	always_comb begin
		ctrl_d = ctrl_wr;
		// Bus reset wins over a host write in the same cycle
		if (bus_reset_i) begin
			ctrl_d[`LCR_TRANSMITTER_EN_BIT] = 1'b0;
		end
		// Receiver enable is deliberately untouched by bus reset
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_q <= `LCR_CTRL_RST;
			por_q <= 1'b1;
		end else begin
			ctrl_q <= ctrl_d;
			por_q <= 1'b0;
		end
	end

	assign self_id_receive_en_o = ctrl_q[`LCR_SIDR_BIT];
	assign busy_ack_policy_o = ctrl_q[`LCR_BUSY_MSB:`LCR_BUSY_LSB];
	assign transmitter_en_o = ctrl_q[`LCR_TRANSMITTER_EN_BIT];
	assign receiver_en_o = ctrl_q[`LCR_RECEIVER_EN_BIT];
	assign transmitter_soft_reset_o = ctrl_q[`LCR_TXRST_BIT];
	assign receiver_soft_reset_o = ctrl_q[`LCR_RXRST_BIT];

	// --------------------------------------------------------------
	// Read path
	// --------------------------------------------------------------
	wire logic [31:0] rd_mux;
	logic [31:0] rdata_q;
	logic ack_out_q;
	lcr_region_t region_q;

	// Locations outside this front section answer zero
	assign rd_mux = (bus.addr == `LCR_OFS_VERSION) ? VERSION_ID :
		(bus.addr == `LCR_OFS_MISC) ?
		{4'h0, ack_q, 23'h000000} :
		(bus.addr == `LCR_OFS_CTRL) ? ctrl_q :
		32'h0000_0000;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_q <= `LCR_RDATA_RST;
			ack_out_q <= 1'b0;
			region_q <= LCR_REG_RSVD;
		end else begin
			if (rd_take) begin
				rdata_q <= rd_mux;
			end
			if (take) begin
				ack_out_q <= 1'b1;
				region_q <= region;
			end else if (bus.cs_b) begin
				ack_out_q <= 1'b0;
			end
		end
	end

	assign lb_rdata_o = rdata_q;
	assign lb_ack_o = ack_out_q;
	assign lb_region_o = region_q;

	// --------------------------------------------------------------
	// Busy acknowledge selection
	// --------------------------------------------------------------
	wire logic busy_send;
	wire lcr_busy_kind_t busy_kind;
	logic busy_valid_q;
	logic busy_send_q;
	lcr_busy_kind_t busy_kind_q;

	lcr_busy_sel u_busy_sel (
		.policy_i(ctrl_q[`LCR_BUSY_MSB:`LCR_BUSY_LSB]),
		.busy_needed_i(rx_busy_needed_i),
		.retry_i(rx_retry_i),
		.send_busy_o(busy_send),
		.kind_o(busy_kind)
	);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			busy_valid_q <= 1'b0;
			busy_send_q <= 1'b0;
			busy_kind_q <= LCR_BUSY_X;
		end else begin
			busy_valid_q <= rx_busy_req_i;
			if (rx_busy_req_i) begin
				busy_send_q <= busy_send;
				busy_kind_q <= busy_kind;
			end
		end
	end

	assign ack_busy_valid_o = busy_valid_q;
	assign ack_busy_send_o = busy_send_q;
	assign ack_busy_kind_o = busy_kind_q;

endmodule : lcr_front

// File: bench/lcr_front_assertions.sv
`timescale 1ns/1ps
module lcr_front_chk
	import lcr_pkg::*;
#(
	parameter logic [31:0] VERSION_ID = 32'h0000_0000,
	parameter int SYNC_STAGES = 2
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Local bus
	input wire logic lb_we_b_i,
	input wire logic [7:0] local_address_lines_i,
	input wire logic [31:0] lb_rdata_o,
	input wire logic lb_ack_o,
	input wire lcr_region_t lb_region_o,
	// Link and receiver inputs
	input wire logic bus_reset_i,
	input wire logic rx_busy_req_i,
	input wire logic rx_busy_needed_i,
	input wire lcr_retry_t rx_retry_i,
	// Control and busy outputs
	input wire logic [2:0] busy_ack_policy_o,
	input wire logic transmitter_en_o,
	input wire logic receiver_en_o,
	input wire logic transmitter_soft_reset_o,
	input wire logic receiver_soft_reset_o,
	input wire logic ack_busy_valid_o,
	input wire logic ack_busy_send_o,
	input wire lcr_busy_kind_t ack_busy_kind_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// -----------------------------------------------------------
	// Register access
	// -----------------------------------------------------------
	// Ack rises one edge after the take edge, pins still held
	AST_VERSION_RO: assert property ($rose(lb_ack_o) && lb_we_b_i
		&& local_address_lines_i == 8'h00 |-> lb_rdata_o == VERSION_ID)
		else $error("version word read wrong");
	AST_ISO_REGION: assert property ($rose(lb_ack_o) &&
		local_address_lines_i inside {[8'h54:8'h5C]}
		|-> lb_region_o == LCR_REG_ISO) else $error("iso region wrong");
	AST_UNMAPPED_ZERO: assert property ($rose(lb_ack_o) && lb_we_b_i
		&& local_address_lines_i > 8'h08 |-> lb_rdata_o == 32'h0)
		else $error("unmapped read not zero");
	// -----------------------------------------------------------
	// Control bits
	// -----------------------------------------------------------
	AST_TRANSMITTER_EN_BUSRST: assert property (bus_reset_i |=>
		!transmitter_en_o) else $error("tx enable kept on bus reset");
	// Depth two covers the power-on default landing after release
	AST_RECEIVER_EN_KEPT: assert property ($changed(receiver_en_o) |->
		$rose(lb_ack_o) || !$past(rst_b_i, 2))
		else $error("rx enable moved without a write");
	AST_TX_SOFTRST: assert property (transmitter_soft_reset_o |->
		$rose(lb_ack_o) ##1 !transmitter_soft_reset_o)
		else $error("tx soft reset not a single pulse");
	AST_RX_SOFTRST: assert property (receiver_soft_reset_o |->
		$rose(lb_ack_o) ##1 !receiver_soft_reset_o)
		else $error("rx soft reset not a single pulse");
	// -----------------------------------------------------------
	// Busy decision
	// -----------------------------------------------------------
	AST_BUSY_VALID: assert property ($past(rx_busy_req_i) ==
		ack_busy_valid_o) else $error("busy valid timing wrong");
	AST_BUSY_SEND: assert property (rx_busy_req_i |=> ack_busy_send_o
		== ($past(busy_ack_policy_o[2]) | $past(rx_busy_needed_i)))
		else $error("busy send wrong");
	AST_BUSY_FIXED_A: assert property (rx_busy_req_i &&
		busy_ack_policy_o[1:0] == 2'b01 |=> ack_busy_kind_o == LCR_BUSY_A)
		else $error("busy A policy ignored");
	AST_BUSY_FIXED_B: assert property (rx_busy_req_i &&
		busy_ack_policy_o[1:0] == 2'b10 |=> ack_busy_kind_o == LCR_BUSY_B)
		else $error("busy B policy ignored");
	AST_BUSY_RETRY_X: assert property (rx_busy_req_i &&
		rx_retry_i == LCR_RETRY_X && busy_ack_policy_o[1] ==
		busy_ack_policy_o[0] |=> ack_busy_kind_o == LCR_BUSY_X)
		else $error("retry X not answered busy X");
endmodule : lcr_front_chk

bind lcr_front lcr_front_chk #(
	.VERSION_ID(VERSION_ID),
	.SYNC_STAGES(SYNC_STAGES)
) chk_u (
	.clk_i(clk_i),
	.rst_b_i(rst_b_i),
	.lb_we_b_i(lb_we_b_i),
	.local_address_lines_i(local_address_lines_i),
	.lb_rdata_o(lb_rdata_o),
	.lb_ack_o(lb_ack_o),
	.lb_region_o(lb_region_o),
	.bus_reset_i(bus_reset_i),
	.rx_busy_req_i(rx_busy_req_i),
	.rx_busy_needed_i(rx_busy_needed_i),
	.rx_retry_i(rx_retry_i),
	.busy_ack_policy_o(busy_ack_policy_o),
	.transmitter_en_o(transmitter_en_o),
	.receiver_en_o(receiver_en_o),
	.transmitter_soft_reset_o(transmitter_soft_reset_o),
	.receiver_soft_reset_o(receiver_soft_reset_o),
	.ack_busy_valid_o(ack_busy_valid_o),
	.ack_busy_send_o(ack_busy_send_o),
	.ack_busy_kind_o(ack_busy_kind_o)
);

// File: bench/lcr_host.sv
`timescale 1ns/1ps
module lcr_host (
	// Clock
	input wire logic clk_i,
	// Local bus pins
	output logic cs_b_o,
	output logic we_b_o,
	output logic [7:0] addr_o,
	output logic [31:0] wdata_o,
	input wire logic [31:0] rdata_i,
	input wire logic ack_i
);
	initial begin
		cs_b_o = 1'b1;
		we_b_o = 1'b1;
		addr_o = 8'h00;
		wdata_o = 32'h0000_0000;
	end
	// Pins held from select until ack is seen; ok stays low on no ack
	task automatic access(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic ok);
		int n;
		q = 'x;
		ok = 1'b0;
		@(posedge clk_i);
		cs_b_o <= 1'b0;
		we_b_o <= !wr;
		addr_o <= a;
		wdata_o <= d;
		for (n = 0; n < 12 && !ok; n++) begin
			@(posedge clk_i);
			if (ack_i === 1'b1) begin
				q = rdata_i;
				ok = 1'b1;
			end
		end
		cs_b_o <= 1'b1;
		// Deselected pins carry junk, not the last value
		addr_o <= ~a;
		wdata_o <= ~d;
		for (n = 0; n < 12 && ack_i !== 1'b0; n++)
			@(posedge clk_i);
		// An ack that never drops is a hung bus as well
		if (ack_i !== 1'b0) begin
			ok = 1'b0;
		end
		repeat (3) @(posedge clk_i);
	endtask : access
endmodule : lcr_host

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import lcr_pkg::*;
	// Arbitrary identification value
	localparam logic [31:0] VID = 32'h1234_ABCD;
	logic clk_i, rst_b_i, lb_cs_b_i, lb_we_b_i, lb_ack_o;
	logic [7:0] local_address_lines_i;
	logic [31:0] lb_wdata_i, lb_rdata_o, q;
	lcr_region_t lb_region_o;
	logic diag_register_write_i, bus_reset_i, ack_valid_i;
	logic [4:0] ack_code_i;
	logic rx_busy_req_i, rx_busy_needed_i;
	lcr_retry_t rx_retry_i;
	logic self_id_receive_en_o, transmitter_en_o, receiver_en_o;
	logic [2:0] busy_ack_policy_o;
	logic transmitter_soft_reset_o, receiver_soft_reset_o;
	logic ack_busy_valid_o, ack_busy_send_o;
	lcr_busy_kind_t ack_busy_kind_o;
	int mismatches, compares;
	int tx_pulses, rx_pulses;

	lcr_front #(
		.VERSION_ID(VID)
	) dut_u (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.lb_cs_b_i(lb_cs_b_i),
		.lb_we_b_i(lb_we_b_i),
		.local_address_lines_i(local_address_lines_i),
		.lb_wdata_i(lb_wdata_i),
		.lb_rdata_o(lb_rdata_o),
		.lb_ack_o(lb_ack_o),
		.lb_region_o(lb_region_o),
		.diag_register_write_i(diag_register_write_i),
		.bus_reset_i(bus_reset_i),
		.ack_valid_i(ack_valid_i),
		.ack_code_i(ack_code_i),
		.rx_busy_req_i(rx_busy_req_i),
		.rx_busy_needed_i(rx_busy_needed_i),
		.rx_retry_i(rx_retry_i),
		.self_id_receive_en_o(self_id_receive_en_o),
		.busy_ack_policy_o(busy_ack_policy_o),
		.transmitter_en_o(transmitter_en_o),
		.receiver_en_o(receiver_en_o),
		.transmitter_soft_reset_o(transmitter_soft_reset_o),
		.receiver_soft_reset_o(receiver_soft_reset_o),
		.ack_busy_valid_o(ack_busy_valid_o),
		.ack_busy_send_o(ack_busy_send_o),
		.ack_busy_kind_o(ack_busy_kind_o)
	);
	lcr_host host_u (
		.clk_i(clk_i),
		.cs_b_o(lb_cs_b_i),
		.we_b_o(lb_we_b_i),
		.addr_o(local_address_lines_i),
		.wdata_o(lb_wdata_i),
		.rdata_i(lb_rdata_o),
		.ack_i(lb_ack_o)
	);

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// Cycles seen with a soft reset high; a pulse must add exactly one
	always @(posedge clk_i) begin
		if (transmitter_soft_reset_o === 1'b1) begin
			tx_pulses <= tx_pulses + 1;
		end
		if (receiver_soft_reset_o === 1'b1) begin
			rx_pulses <= rx_pulses + 1;
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ok;
		host_u.access(1'b1, a, d, q, ok);
		check({31'h0, ok}, 32'h0000_0001);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		logic ok;
		host_u.access(1'b0, a, 32'h0000_0000, q, ok);
		check({31'h0, ok}, 32'h0000_0001);
	endtask : rd

	task automatic print_verdict;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	// -----------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------
	task automatic t_version;
		rd(8'h00);
		check(q, VID);
		wr(8'h00, ~VID);
		rd(8'h00);
		check(q, VID);
	endtask : t_version

	task automatic t_region;
		logic [7:0] ad [9] = '{8'h0C, 8'h50, 8'h54, 8'h5C, 8'h80,
			8'hCC, 8'hD0, 8'hF8, 8'h60};
		logic [3:0] rg [9] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h4, 4'h4,
			4'h8, 4'h8, 4'h8};
		for (int i = 0; i < 9; i++) begin
			rd(ad[i]);
			check(q, 32'h0000_0000);
			check({28'h0, lb_region_o}, {28'h0, rg[i]});
		end
	endtask : t_region

	task automatic t_misc;
		@(posedge clk_i);
		ack_code_i <= 5'h15;
		ack_valid_i <= 1'b1;
		@(posedge clk_i);
		ack_valid_i <= 1'b0;
		rd(8'h04);
		check(q, 32'h0A80_0000);
		// Without the diagnostic write bit the field must not move
		wr(8'h04, 32'hFFFF_FFFF);
		rd(8'h04);
		check(q, 32'h0A80_0000);
		diag_register_write_i <= 1'b1;
		wr(8'h04, 32'hFFFF_FFFF);
		diag_register_write_i <= 1'b0;
		rd(8'h04);
		check(q, 32'h0F80_0000);
	endtask : t_misc

	task automatic t_ctrl;
		wr(8'h08, 32'hFFFF_FFFF);
		rd(8'h08);
		check(q, 32'h0FF3_807E);
		check(tx_pulses, 32'h0000_0001);
		check(rx_pulses, 32'h0000_0001);
		check({31'h0, transmitter_en_o}, 32'h0000_0001);
		@(posedge clk_i);
		bus_reset_i <= 1'b1;
		@(posedge clk_i);
		bus_reset_i <= 1'b0;
		@(posedge clk_i);
		check({30'h0, transmitter_en_o, receiver_en_o},
			32'h0000_0001);
		// The host may still turn reception off by a write
		wr(8'h08, 32'h0000_0000);
		check({31'h0, receiver_en_o}, 32'h0000_0000);
	endtask : t_ctrl

	task automatic t_busy;
		logic [3:0] p, k;
		logic [1:0] ek;
		for (p = 0; p < 8; p++) begin
			wr(8'h08, {25'h0, 1'b1, 1'b0, p[2:0], 2'b00});
			check({29'h0, busy_ack_policy_o},
				{29'h0, p[2:0]});
			for (k = 0; k < 8; k++) begin
				@(posedge clk_i);
				rx_busy_req_i <= 1'b1;
				rx_busy_needed_i <= k[2];
				rx_retry_i <= lcr_retry_t'(k[1:0]);
				@(posedge clk_i);
				rx_busy_req_i <= 1'b0;
				@(posedge clk_i);
				ek = (p[1] ^ p[0]) ? p[1:0] : (k[1] ? k[1:0] - 2'b01 : 2'b00);
				check({28'h0, ack_busy_valid_o, ack_busy_send_o,
					ack_busy_kind_o},
					{28'h0, 1'b1, p[2] | k[2], ek});
			end
		end
	endtask : t_busy

	initial begin
		#100000;
		mismatches++;
		print_verdict;
	end

	initial begin
		rst_b_i = 1'b0;
		diag_register_write_i = 1'b0;
		bus_reset_i = 1'b0;
		ack_valid_i = 1'b0;
		ack_code_i = 5'h00;
		rx_busy_req_i = 1'b0;
		rx_busy_needed_i = 1'b0;
		rx_retry_i = LCR_RETRY_NEW;
		repeat (4) @(posedge clk_i);
		check({30'h0, self_id_receive_en_o, receiver_en_o},
			32'h0000_0000);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rd(8'h08);
		check(q, 32'h0200_0042);
		check({31'h0, self_id_receive_en_o}, 32'h0000_0001);
		t_version;
		t_region;
		t_misc;
		t_ctrl;
		t_busy;
		print_verdict;
	end
endmodule : testbench
